// >>> hdl/pvl_vector_loader.sv
// Command handler for a pattern generator's vector memory.
// Assumes commands arrive already parsed, on the mclk domain.
`default_nettype none
`include "pvl_defs.svh"

module pvl_vector_loader #(
	parameter int NSIG  = 16,
	parameter int NGRP  = 8,
	parameter int DEPTH = 1024,
	parameter int FDEP  = 32
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// Command port
	input  wire logic                   cmdValid,
	output logic                        cmdReady,
	input  wire pvl_pkg::cmd_s          cmd,
	// ASCII data in
	input  wire logic                   charValid,
	output logic                        charReady,
	input  wire logic [7:0]             charData,
	// Response out
	output logic                        respValid,
	input  wire logic                   respReady,
	output pvl_pkg::resp_s              resp,
	// Status and settings
	input  wire logic                   opsPending,
	input  wire logic [15:0]            loopAddr,
	output logic                        busy,
	output logic                        execErr,
	output logic                        dataErr,
	output logic                        verboseOn,
	output logic [15:0]                 startAddr,
	output logic [15:0]                 endAddr
);
	localparam int AW = $clog2(DEPTH);
	localparam int GW = $clog2(NGRP + 1);

	pvl_pkg::state_e     state_reg;
	pvl_pkg::state_e     state_next;
	pvl_pkg::op_e        op_reg;
	pvl_pkg::resp_kind_e numKind_reg;
	pvl_pkg::resp_s      resp_reg;
	pvl_pkg::grp_s       grp_reg [2**GW];
	pvl_pkg::grp_s       curGrp;
	logic                respValid_reg;
	logic                numAll_reg;
	logic                isCommon_reg;
	logic                verbose_reg;
	logic                execErr_reg;
	logic                dataErr_reg;
	logic [15:0]         start_reg;
	logic [15:0]         end_reg;
	logic [15:0]         vecAddr_reg;
	logic [15:0]         remain_reg;
	logic [GW-1:0]       grpIdx_reg;
	logic [GW-1:0]       grpCount_reg;
	logic [4:0]          digits_reg;
	logic [15:0]         acc_reg;
	logic [NSIG-1:0]     vecBuf_reg;
	logic [NSIG-1:0]     memQ;
	logic [NSIG-1:0]     vmem [DEPTH];

	// Incoming characters are buffered in an FDEP-deep FIFO; the link waits only when it is full
	logic       fifoValid;
	logic       fifoReady;
	logic [7:0] fifoData;

	pvl_fifo #(
		.WIDTH (8),
		.DEPTH (FDEP)
	) u_fifo (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.inValid  (charValid),
		.inReady  (charReady),
		.inData   (charData),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoData)
	);

	// Group value from vector bits, bit 0 being the least significant
	function automatic logic [15:0] gather(input logic [NSIG-1:0] v,
		input pvl_pkg::grp_s g);
		logic [15:0] r;
		int          s;
		r = '0;
		for (int j = 0; j < 16; j++) begin
			s = g.desc ? int'(g.lo) + j : int'(g.lo) + int'(g.wid) - 1 - j;
			if (j < int'(g.wid) && s >= 0 && s < NSIG)
				r[j] = v[s];
		end
		return r;
	endfunction : gather

	// Group value back into the vector; signals outside stay untouched
	function automatic logic [NSIG-1:0] scatter(input logic [NSIG-1:0] v,
		input pvl_pkg::grp_s g, input logic [15:0] val);
		logic [NSIG-1:0] r;
		int              s;
		r = v;
		for (int j = 0; j < 16; j++) begin
			s = g.desc ? int'(g.lo) + j : int'(g.lo) + int'(g.wid) - 1 - j;
			if (j < int'(g.wid) && s >= 0 && s < NSIG)
				r[s] = val[j];
		end
		return r;
	endfunction : scatter

	// Command decode
	wire take      = cmdValid && (state_reg == pvl_pkg::ST_IDLE);
	wire isLoad    = op_reg == pvl_pkg::OP_DATA_LOAD;
	wire grpFull   = grpCount_reg == GW'(NGRP);
	wire [5:0] grpTop = 6'(cmd.grp.lo) + 6'(cmd.grp.wid);
	wire grpBad    = grpFull || (cmd.grp.wid == '0) || (grpTop > 6'(NSIG));
	wire addGrp    = take && cmd.op == pvl_pkg::OP_LAYOUT_ADD;

	// Range check on the latched address and count
	wire [16:0] rangeEnd = 17'(vecAddr_reg) + 17'(remain_reg);
	wire rangeBad  = rangeEnd > 17'(DEPTH);
	wire noWork    = (remain_reg == '0) || (grpCount_reg == '0);

	// Walk position
	assign curGrp  = grp_reg[grpIdx_reg];
	wire lastGrp   = grpIdx_reg == grpCount_reg - GW'(1);
	wire lastDigit = digits_reg == 5'd1;
	wire lastVec   = remain_reg == 16'd1;
	wire [4:0] hexDigits = 5'((curGrp.wid + 5'd3) >> 2);
	wire [4:0] grpDigits = curGrp.hex ? hexDigits : curGrp.wid;

	// Input character decode
	wire chDec = fifoData >= `PVL_CH_0 && fifoData <= `PVL_CH_9;
	wire chUp  = fifoData >= `PVL_CH_UA && fifoData <= `PVL_CH_UF;
	wire chLo  = fifoData >= `PVL_CH_LA && fifoData <= `PVL_CH_LF;
	wire chBin = fifoData == `PVL_CH_0 || fifoData == `PVL_CH_1;
	wire [7:0] chOfs = chUp ? `PVL_OFS_UP : chLo ? `PVL_OFS_LO : `PVL_OFS_DEC;
	wire [3:0] inNib = 4'(fifoData - chOfs);
	wire chOk  = curGrp.hex ? (chDec || chUp || chLo) : chBin;
	wire [15:0] accIn = curGrp.hex ? {acc_reg[11:0], inNib}
		: {acc_reg[14:0], fifoData == `PVL_CH_1};
	wire takeCh = (state_reg == pvl_pkg::ST_LDCH) && fifoValid;

	// Output digit encode, most significant digit first
	wire [4:0] digIdx  = digits_reg - 5'd1;
	wire [15:0] accSh  = acc_reg >> {digIdx, 2'b00};
	wire [3:0] outNib  = accSh[3:0];
	wire outBit        = acc_reg[digIdx[3:0]];
	wire [7:0] hexCh   = outNib < 4'hA ? `PVL_OFS_DEC + 8'(outNib)
		: `PVL_OFS_UP + 8'(outNib);
	wire [7:0] binCh   = outBit ? `PVL_CH_1 : `PVL_CH_0;
	wire [7:0] outCh   = curGrp.hex ? hexCh : binCh;

	// Response slot
	wire respFree  = !respValid_reg || respReady;
	wire emitCh    = (state_reg == pvl_pkg::ST_QCH) && respFree;
	wire emitNum   = (state_reg == pvl_pkg::ST_NUM) && respFree;
	wire numDone   = !numAll_reg || numKind_reg == pvl_pkg::RK_END;
	wire longHdr   = verbose_reg && !isCommon_reg;
	wire [15:0] numVal =
		numKind_reg == pvl_pkg::RK_START   ? start_reg :
		numKind_reg == pvl_pkg::RK_LOOP    ? loopAddr  :
		numKind_reg == pvl_pkg::RK_END     ? end_reg   :
		{15'h0000, verbose_reg};

	// Hold leaves once outside work and own output have drained
	wire idleNow   = !opsPending && !respValid_reg;

	assign cmdReady  = state_reg == pvl_pkg::ST_IDLE;
	assign fifoReady = state_reg == pvl_pkg::ST_LDCH;
	assign respValid = respValid_reg;
	assign resp      = resp_reg;
	assign busy      = state_reg != pvl_pkg::ST_IDLE;
	assign execErr   = execErr_reg;
	assign dataErr   = dataErr_reg;
	assign verboseOn = verbose_reg;
	assign startAddr = start_reg;
	assign endAddr   = end_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pvl_pkg::ST_IDLE: begin
				if (take) begin
					case (cmd.op)
						pvl_pkg::OP_DATA_LOAD,
						pvl_pkg::OP_DATA_QUERY: state_next = pvl_pkg::ST_CHECK;
						pvl_pkg::OP_END_QUERY,
						pvl_pkg::OP_START_QRY,
						pvl_pkg::OP_VERB_QUERY,
						pvl_pkg::OP_VECT_QUERY: state_next = pvl_pkg::ST_NUM;
						pvl_pkg::OP_HOLD_IDLE: state_next = pvl_pkg::ST_WAIT;
						default: state_next = pvl_pkg::ST_IDLE;
					endcase
				end
			end
			pvl_pkg::ST_CHECK: begin
				if (rangeBad || noWork)
					state_next = pvl_pkg::ST_IDLE;
				else
					state_next = pvl_pkg::ST_RD;
			end
			pvl_pkg::ST_RD:    state_next = pvl_pkg::ST_FETCH;
			pvl_pkg::ST_FETCH: state_next = pvl_pkg::ST_GRP;
			pvl_pkg::ST_GRP: begin
				state_next = isLoad ? pvl_pkg::ST_LDCH : pvl_pkg::ST_QCH;
			end
			pvl_pkg::ST_LDCH: begin
				if (takeCh && lastDigit)
					state_next = pvl_pkg::ST_SCAT;
			end
			pvl_pkg::ST_SCAT: begin
				state_next = lastGrp ? pvl_pkg::ST_WRITE : pvl_pkg::ST_GRP;
			end
			pvl_pkg::ST_WRITE: state_next = pvl_pkg::ST_NEXT;
			pvl_pkg::ST_NEXT: begin
				state_next = lastVec ? pvl_pkg::ST_IDLE : pvl_pkg::ST_RD;
			end
			pvl_pkg::ST_QCH: begin
				if (emitCh && lastDigit)
					state_next = lastGrp ? pvl_pkg::ST_NEXT : pvl_pkg::ST_GRP;
			end
			pvl_pkg::ST_NUM: begin
				if (emitNum && numDone)
					state_next = pvl_pkg::ST_IDLE;
			end
			pvl_pkg::ST_WAIT: begin
				if (idleNow)
					state_next = pvl_pkg::ST_IDLE;
			end
			default: state_next = pvl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			state_reg <= pvl_pkg::ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Layout table; changes only between commands, so a walk sees one
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			grpCount_reg <= '0;
			for (int i = 0; i < 2**GW; i++)
				grp_reg[i] <= '0;
		end else if (take && cmd.op == pvl_pkg::OP_LAYOUT_CLR) begin
			grpCount_reg <= '0;
		end else if (addGrp && !grpBad) begin
			grp_reg[grpCount_reg] <= cmd.grp;
			grpCount_reg <= grpCount_reg + GW'(1);
		end
	end

	// Settings
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			start_reg    <= `PVL_ADDR_RST;
			end_reg      <= `PVL_ADDR_RST;
			verbose_reg  <= `PVL_VERBOSE_RST;
			isCommon_reg <= 1'b0;
			op_reg       <= pvl_pkg::OP_NOP;
		end else if (take) begin
			op_reg       <= cmd.op;
			isCommon_reg <= cmd.isCommon;
			if (cmd.op == pvl_pkg::OP_START_SET)
				start_reg <= cmd.arg;
			if (cmd.op == pvl_pkg::OP_END_SET)
				end_reg <= cmd.arg;
			if (cmd.op == pvl_pkg::OP_VERB_SET)
				verbose_reg <= cmd.arg != '0;
		end
	end

	// Numeric answer sequencing
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			numKind_reg <= pvl_pkg::RK_START;
			numAll_reg  <= 1'b0;
		end else if (take) begin
			numAll_reg <= cmd.op == pvl_pkg::OP_VECT_QUERY;
			case (cmd.op)
				pvl_pkg::OP_END_QUERY:  numKind_reg <= pvl_pkg::RK_END;
				pvl_pkg::OP_VERB_QUERY: numKind_reg <= pvl_pkg::RK_VERBOSE;
				default:                numKind_reg <= pvl_pkg::RK_START;
			endcase
		end else if (emitNum && !numDone) begin
			numKind_reg <= numKind_reg == pvl_pkg::RK_START
				? pvl_pkg::RK_LOOP : pvl_pkg::RK_END;
		end
	end

	// Vector walk
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vecAddr_reg <= '0;
			remain_reg  <= '0;
			grpIdx_reg  <= '0;
			digits_reg  <= '0;
			acc_reg     <= '0;
			vecBuf_reg  <= '0;
		end else begin
			if (take) begin
				vecAddr_reg <= cmd.addr;
				remain_reg  <= cmd.count;
			end
			if (state_reg == pvl_pkg::ST_NEXT) begin
				vecAddr_reg <= vecAddr_reg + 16'd1;
				remain_reg  <= remain_reg - 16'd1;
			end
			if (state_reg == pvl_pkg::ST_FETCH) begin
				vecBuf_reg <= memQ;
				grpIdx_reg <= '0;
			end
			if (state_reg == pvl_pkg::ST_GRP) begin
				digits_reg <= grpDigits;
				acc_reg <= isLoad ? 16'h0000 : gather(vecBuf_reg, curGrp);
			end
			if (takeCh) begin
				acc_reg    <= accIn;
				digits_reg <= digits_reg - 5'd1;
			end
			if (emitCh)
				digits_reg <= digits_reg - 5'd1;
			if (state_reg == pvl_pkg::ST_SCAT) begin
				vecBuf_reg <= scatter(vecBuf_reg, curGrp, acc_reg);
				grpIdx_reg <= grpIdx_reg + GW'(1);
			end
			if (emitCh && lastDigit)
				grpIdx_reg <= grpIdx_reg + GW'(1);
		end
	end

	// Responses stay until the reader takes them
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			respValid_reg <= 1'b0;
			resp_reg      <= '0;
		end else if (emitCh) begin
			respValid_reg  <= 1'b1;
			resp_reg.kind  <= pvl_pkg::RK_CHAR;
			resp_reg.value <= {8'h00, outCh};
			resp_reg.last  <= lastDigit && lastGrp && lastVec;
			resp_reg.longHdr <= longHdr;
		end else if (emitNum) begin
			respValid_reg  <= 1'b1;
			resp_reg.kind  <= numKind_reg;
			resp_reg.value <= numVal;
			resp_reg.last  <= numDone;
			resp_reg.longHdr <= longHdr;
		end else if (respReady) begin
			respValid_reg <= 1'b0;
		end
	end

	// One-cycle error pulses
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			execErr_reg <= 1'b0;
			dataErr_reg <= 1'b0;
		end else begin
			execErr_reg <= (addGrp && grpBad)
				|| (state_reg == pvl_pkg::ST_CHECK && rangeBad);
			dataErr_reg <= takeCh && !chOk;
		end
	end

	// Vector memory; read data registered, read-modify-write per vector
	always_ff @(posedge mclk) begin
		memQ <= vmem[vecAddr_reg[AW-1:0]];
		if (state_reg == pvl_pkg::ST_WRITE)
			vmem[vecAddr_reg[AW-1:0]] <= vecBuf_reg;
	end

endmodule : pvl_vector_loader

`default_nettype wire

// >>> hdl/pvl_defs.svh
// Constants of the pattern vector command loader.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PVL_DEFS_SVH
`define PVL_DEFS_SVH

// Reset values
`define PVL_ADDR_RST    16'h0000
`define PVL_VERBOSE_RST 1'b1

// Field widths
`define PVL_WORD_W      16
`define PVL_HEX_BITS    4

// ASCII character codes
`define PVL_CH_0        8'h30
`define PVL_CH_1        8'h31
`define PVL_CH_9        8'h39
`define PVL_CH_UA       8'h41
`define PVL_CH_UF       8'h46
`define PVL_CH_LA       8'h61
`define PVL_CH_LF       8'h66
// Offsets from character code to digit value
`define PVL_OFS_DEC     8'h30
`define PVL_OFS_UP      8'h37
`define PVL_OFS_LO      8'h57

`endif

// >>> hdl/pvl_pkg.sv
// Types of the pattern vector command loader.
// Assumes pvl_defs.svh sits on the include path.
`default_nettype none
`include "pvl_defs.svh"

package pvl_pkg;

	typedef enum logic [3:0] {
		OP_NOP        = 4'h0,
		OP_LAYOUT_CLR = 4'h1,
		OP_LAYOUT_ADD = 4'h2,
		OP_DATA_LOAD  = 4'h3,
		OP_DATA_QUERY = 4'h4,
		OP_END_SET    = 4'h5,
		OP_END_QUERY  = 4'h6,
		OP_START_SET  = 4'h7,
		OP_START_QRY  = 4'h8,
		OP_VERB_SET   = 4'h9,
		OP_VERB_QUERY = 4'hA,
		OP_VECT_QUERY = 4'hB,
		OP_HOLD_IDLE  = 4'hC
	} op_e;

	typedef enum logic [2:0] {
		RK_CHAR    = 3'h0,
		RK_START   = 3'h1,
		RK_LOOP    = 3'h2,
		RK_END     = 3'h3,
		RK_VERBOSE = 3'h4
	} resp_kind_e;

	typedef enum logic [11:0] {
		ST_IDLE  = 12'h001,
		ST_CHECK = 12'h002,
		ST_RD    = 12'h004,
		ST_FETCH = 12'h008,
		ST_GRP   = 12'h010,
		ST_LDCH  = 12'h020,
		ST_SCAT  = 12'h040,
		ST_WRITE = 12'h080,
		ST_NEXT  = 12'h100,
		ST_QCH   = 12'h200,
		ST_NUM   = 12'h400,
		ST_WAIT  = 12'h800
	} state_e;

	typedef struct packed {
		logic [3:0] lo;
		logic [4:0] wid;
		logic       desc;
		logic       hex;
	} grp_s;

	typedef struct packed {
		op_e                      op;
		logic                     isCommon;
		logic [`PVL_WORD_W-1:0]   addr;
		logic [`PVL_WORD_W-1:0]   count;
		logic [`PVL_WORD_W-1:0]   arg;
		grp_s                     grp;
	} cmd_s;

	typedef struct packed {
		resp_kind_e               kind;
		logic                     longHdr;
		logic                     last;
		logic [`PVL_WORD_W-1:0]   value;
	} resp_s;

endpackage : pvl_pkg

`default_nettype wire

// >>> hdl/pvl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on mclk.
`default_nettype none

module pvl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wrPtr_reg;
	logic [PW-1:0]    rdPtr_reg;
	logic [CW-1:0]    count_reg;

	wire push = inValid && inReady;
	wire pop  = outValid && outReady;

	assign inReady  = count_reg != CW'(DEPTH);
	assign outValid = count_reg != '0;
	assign outData  = store[rdPtr_reg];

	always_ff @(posedge mclk) begin
		if (push)
			store[wrPtr_reg] <= inData;
	end

	// Pointers wrap at DEPTH so any depth works
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			if (pop)
				rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end

endmodule : pvl_fifo

`default_nettype wire

// >>> bench/pvl_vector_loader_asserts.sv
// Port checker for the vector command loader.
// Assumes it is bound onto every pvl_vector_loader instance.
`default_nettype none

module pvl_vector_loader_asserts #(
	parameter int DEPTH = 1024
) (
	// Clock and reset
	input wire logic           mclk,
	input wire logic           rst_n,
	// Command and reply
	input wire logic           cmdValid,
	input wire logic           cmdReady,
	input wire pvl_pkg::cmd_s  cmd,
	input wire logic           respValid,
	input wire pvl_pkg::resp_s resp,
	// Status
	input wire logic           opsPending,
	input wire logic           execErr,
	input wire logic           verboseOn,
	input wire logic [15:0]    startAddr,
	input wire logic [15:0]    endAddr
);
	wire        take = cmdValid && cmdReady;
	// Extra bit so a range ending past the top cannot wrap
	wire [16:0] span = {1'b0, cmd.addr} + {1'b0, cmd.count};
	wire        rng = take && cmd.count != 16'h0000 && span > 17'(DEPTH)
		&& cmd.op inside {pvl_pkg::OP_DATA_LOAD, pvl_pkg::OP_DATA_QUERY};

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_verb_set: assert property (
		take && cmd.op == pvl_pkg::OP_VERB_SET
		|=> verboseOn == ($past(cmd.arg) != 16'h0000))
		else $error("verbose setting wrong");
	a_end_set: assert property (
		take && cmd.op == pvl_pkg::OP_END_SET |=> endAddr == $past(cmd.arg))
		else $error("end address not stored");
	a_verb_reply: assert property (
		take && cmd.op == pvl_pkg::OP_VERB_QUERY
		|-> ##[1:3] (respValid && resp.value == {15'h0000, verboseOn}))
		else $error("verbose reply wrong");
	a_common_short: assert property (
		take && cmd.isCommon |-> ##[1:3] (respValid && !resp.longHdr))
		else $error("common reply has long header");
	a_hold_wait: assert property (
		take && cmd.op == pvl_pkg::OP_HOLD_IDLE
		|=> !cmdReady until !opsPending)
		else $error("command taken while held");
	a_range_err: assert property (
		rng |-> ##[1:3] execErr)
		else $error("range error missing");
	a_range_quiet: assert property (
		rng |=> !respValid [*6])
		else $error("reply after range error");
	a_vect_start: assert property (
		take && cmd.op == pvl_pkg::OP_VECT_QUERY
		|-> ##[1:3] (respValid && resp.kind == pvl_pkg::RK_START
		&& resp.value == startAddr))
		else $error("combined reply start wrong");

endmodule : pvl_vector_loader_asserts

bind pvl_vector_loader pvl_vector_loader_asserts #(.DEPTH(DEPTH)) i_chk (
	.mclk(mclk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.cmd(cmd), .respValid(respValid), .resp(resp), .opsPending(opsPending),
	.execErr(execErr), .verboseOn(verboseOn), .startAddr(startAddr),
	.endAddr(endAddr)
);

`default_nettype wire

// >>> bench/pvl_ctl_model.sv
// Remote controller stand-in: feeds ASCII data, collects replies.
// Assumes the loader shares its mclk.
`default_nettype none

module pvl_ctl_model (
	// Clock
	input  wire logic           mclk,
	// ASCII data out
	output logic                charValid,
	input  wire logic           charReady,
	output logic [7:0]          charData,
	// Replies in
	input  wire logic           respValid,
	output logic                respReady,
	input  wire pvl_pkg::resp_s resp
);
	timeunit 1ns;
	timeprecision 1ps;
	pvl_pkg::resp_s rx[$];
	logic           slow = 1'b0;
	logic           tick = 1'b0;

	initial begin
		charValid = 1'b0;
		charData = 8'hFF;
		respReady = 1'b1;
	end

	// Slow mode takes a reply every other cycle; logged before the take
	always @(negedge mclk) begin
		tick = ~tick;
		respReady = !slow || tick;
		if (respValid && respReady) begin
			rx.push_back(resp);
		end
	end

	// Held until charReady stands over a rising edge
	task put(input logic [7:0] c);
		@(negedge mclk);
		charValid = 1'b1;
		charData = c;
		while (charReady !== 1'b1) begin
			@(negedge mclk);
		end
		@(negedge mclk);
		charValid = 1'b0;
		charData = ~c;
	endtask : put

endmodule : pvl_ctl_model

`default_nettype wire

// >>> bench/pvl_vector_loader_bench.sv
// Self-checking bench for the vector command loader.
// Assumes design, controller model and checker compile first.
`default_nettype none

module pvl_vector_loader_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic           mclk = 1'b0;
	logic           rst_n = 1'b0;
	logic           cmdValid = 1'b0;
	logic           opsPending = 1'b0;
	logic [15:0]    loopAddr = 16'h0009;
	pvl_pkg::cmd_s  cmd = '0;
	pvl_pkg::grp_s  g0 = '0;
	pvl_pkg::resp_s resp;
	logic           cmdReady, charValid, charReady, respValid, respReady;
	logic           busy, execErr, dataErr, verboseOn, seen;
	logic [7:0]     charData;
	logic [15:0]    startAddr, endAddr;
	int             miscompares = 0;
	int             cmp_count = 0;

	pvl_vector_loader #(.DEPTH(64)) i_dut (
		.mclk(mclk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmd(cmd), .charValid(charValid), .charReady(charReady),
		.charData(charData), .respValid(respValid), .respReady(respReady),
		.resp(resp), .opsPending(opsPending), .loopAddr(loopAddr),
		.busy(busy), .execErr(execErr), .dataErr(dataErr),
		.verboseOn(verboseOn), .startAddr(startAddr), .endAddr(endAddr)
	);
	pvl_ctl_model i_ctl (
		.mclk(mclk), .charValid(charValid), .charReady(charReady),
		.charData(charData), .respValid(respValid), .respReady(respReady),
		.resp(resp)
	);

	always #4 mclk = ~mclk;

	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task test_done();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// Bounded waits, so a stuck loader still reaches the verdict
	task send(input pvl_pkg::op_e o, input logic [15:0] a = 16'h0000,
		input logic [15:0] n = 16'h0000, input logic c = 1'b0);
		int k;
		k = 0;
		@(negedge mclk);
		cmd = '{op: o, isCommon: c, addr: a, count: n, arg: a, grp: g0};
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1 && k < 300) begin
			@(negedge mclk);
			k++;
		end
		@(negedge mclk);
		cmdValid = 1'b0;
		while (busy !== 1'b0 && k < 600) begin
			@(negedge mclk);
			k++;
		end
		chk("command done", 16'h0000, 16'(busy));
	endtask : send

	task addGrp(input logic [3:0] lo, input logic [4:0] w, input logic d,
		input logic h);
		g0 = '{lo: lo, wid: w, desc: d, hex: h};
		send(pvl_pkg::OP_LAYOUT_ADD);
	endtask : addGrp

	task waitResp(input int n);
		int k;
		k = 0;
		while (i_ctl.rx.size() < n && k < 600) begin
			@(negedge mclk);
			k++;
		end
		repeat (4) @(negedge mclk);
		chk("reply count", 16'(n), 16'(i_ctl.rx.size()));
	endtask : waitResp

	task ask(input pvl_pkg::op_e o, input logic c = 1'b0);
		i_ctl.rx.delete();
		send(o, 16'h0000, 16'h0000, c);
		waitResp(1);
	endtask : ask

	task load(input string s, input logic [15:0] a, input logic [15:0] n);
		for (int i = 0; i < s.len(); i++) begin
			i_ctl.put(s[i]);
		end
		send(pvl_pkg::OP_DATA_LOAD, a, n);
	endtask : load

	task query(input string s, input logic [15:0] a, input logic [15:0] n);
		i_ctl.rx.delete();
		send(pvl_pkg::OP_DATA_QUERY, a, n);
		waitResp(s.len());
		for (int i = 0; i < s.len(); i++) begin
			chk("query char", {8'h00, s[i]}, i_ctl.rx[i].value);
			chk("query last", 16'(i == s.len() - 1), i_ctl.rx[i].last);
		end
	endtask : query

	task t_addr();
		send(pvl_pkg::OP_START_SET, 16'h0005);
		send(pvl_pkg::OP_END_SET, 16'h003F);
		chk("start", 16'h0005, startAddr);
		chk("end", 16'h003F, endAddr);
		ask(pvl_pkg::OP_END_QUERY);
		chk("end reply", 16'h003F, i_ctl.rx[0].value);
		ask(pvl_pkg::OP_START_QRY);
		chk("start reply", 16'h0005, i_ctl.rx[0].value);
	endtask : t_addr

	task t_verb();
		logic [15:0] va[4] = '{16'h0000, 16'h0007, 16'h0000, 16'h0001};
		for (int i = 0; i < 4; i++) begin
			send(pvl_pkg::OP_VERB_SET, va[i]);
			chk("verbose", va[i] != 0, verboseOn);
			ask(pvl_pkg::OP_VERB_QUERY);
			chk("verbose reply", va[i] != 0, i_ctl.rx[0].value);
		end
		ask(pvl_pkg::OP_END_QUERY);
		chk("long header", 16'h0001, i_ctl.rx[0].longHdr);
		ask(pvl_pkg::OP_END_QUERY, 1'b1);
		chk("common header", 16'h0000, i_ctl.rx[0].longHdr);
	endtask : t_verb

	// Two groups per vector, then a reversed bus read back the other way
	task t_load();
		send(pvl_pkg::OP_LAYOUT_CLR);
		addGrp(4'h4, 5'h04, 1'b1, 1'b1);
		addGrp(4'h0, 5'h01, 1'b0, 1'b0);
		load("9160", 16'h0002, 16'h0002);
		query("9160", 16'h0002, 16'h0002);
		send(pvl_pkg::OP_LAYOUT_CLR);
		addGrp(4'h8, 5'h04, 1'b0, 1'b1);
		load("C", 16'h0000, 16'h0001);
		send(pvl_pkg::OP_LAYOUT_CLR);
		addGrp(4'h8, 5'h04, 1'b1, 1'b1);
		query("3", 16'h0000, 16'h0001);
	endtask : t_load

	task t_fifo();
		string s;
		s = "01010101010101010101010101010101";
		send(pvl_pkg::OP_LAYOUT_CLR);
		addGrp(4'hF, 5'h01, 1'b1, 1'b0);
		for (int i = 0; i < 32; i++) begin
			i_ctl.put(s[i]);
		end
		chk("fifo full", 16'h0000, charReady);
		send(pvl_pkg::OP_DATA_LOAD, 16'h0020, 16'h0020);
		chk("fifo empty", 16'h0001, charReady);
		i_ctl.slow = 1'b1;
		query(s, 16'h0020, 16'h0020);
		i_ctl.slow = 1'b0;
	endtask : t_fifo

	task t_range();
		pvl_pkg::op_e ops[2] = '{pvl_pkg::OP_DATA_LOAD,
			pvl_pkg::OP_DATA_QUERY};
		for (int i = 0; i < 2; i++) begin
			i_ctl.rx.delete();
			seen = 1'b0;
			fork
				send(ops[i], 16'h003C, 16'h0008);
				repeat (12) @(negedge mclk) seen |= execErr;
			join
			chk("range error", 16'h0001, seen);
			chk("range quiet", 16'h0000, 16'(i_ctl.rx.size()));
		end
		// Zero-width group refused; stray digit flagged
		seen = 1'b0;
		fork
			addGrp(4'h0, 5'h00, 1'b0, 1'b0);
			repeat (6) @(negedge mclk) seen |= execErr;
		join
		chk("group error", 16'h0001, seen);
		seen = 1'b0;
		i_ctl.put("2");
		fork
			send(pvl_pkg::OP_DATA_LOAD, 16'h0000, 16'h0001);
			repeat (12) @(negedge mclk) seen |= dataErr;
		join
		chk("digit error", 16'h0001, seen);
	endtask : t_range

	task t_vect();
		logic [15:0] vv[3] = '{16'h0005, 16'h0009, 16'h003F};
		i_ctl.rx.delete();
		send(pvl_pkg::OP_VECT_QUERY);
		waitResp(3);
		for (int i = 0; i < 3; i++) begin
			chk("vector kind", 16'(i + 1), i_ctl.rx[i].kind);
			chk("vector value", vv[i], i_ctl.rx[i].value);
			chk("vector last", 16'(i == 2), i_ctl.rx[i].last);
		end
	endtask : t_vect

	task t_hold();
		opsPending = 1'b1;
		fork
			send(pvl_pkg::OP_HOLD_IDLE);
			begin
				repeat (24) @(negedge mclk);
				chk("held", 16'h0000, cmdReady);
				opsPending = 1'b0;
			end
		join
		chk("released", 16'h0001, cmdReady);
	endtask : t_hold

	initial begin
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		chk("verbose at reset", 16'h0001, verboseOn);
		chk("start at reset", 16'h0000, startAddr);
		t_addr();
		t_verb();
		t_load();
		t_fifo();
		t_range();
		t_vect();
		t_hold();
		test_done();
	end

	// The tests need under two thousand cycles; the limit is 12500 cycles
	initial begin
		#100000;
		miscompares++;
		test_done();
	end

endmodule : pvl_vector_loader_bench

`default_nettype wire
